// File: hw/cmp_ctrl_pkg.sv
// Purpose: Shared constants for the voltage comparator control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses inside the block's window

package cmp_ctrl_pkg;

  // ---------------------------------------------------------------
  // Bus geometry and register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          CTRL_W        = 16;
  localparam int          STRB_W        = DATA_W / 8;
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // ---------------------------------------------------------------
  // Control register field positions and reset value
  // ---------------------------------------------------------------
  localparam int              EN_BIT     = 10;
  localparam int              NEG_LSB    = 8;
  localparam int              ROUTE_LSB  = 6;
  localparam int              POL_BIT    = 5;
  localparam int              RESP_LSB   = 3;
  localparam int              HYST_BIT   = 2;
  localparam int              RISE_BIT   = 1;
  localparam int              FALL_BIT   = 0;
  localparam int              LO_LANE    = 0;
  localparam int              HI_LANE    = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Status register field positions
  // ---------------------------------------------------------------
  localparam int STAT_RAW_BIT = 0;
  localparam int STAT_RES_BIT = 1;

  // ---------------------------------------------------------------
  // Field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] NEG_HALF_SUPPLY = 2'h0;
  localparam logic [1:0] NEG_ADC_THREE   = 2'h1;
  localparam logic [1:0] NEG_DAC_ZERO    = 2'h2;
  localparam logic [1:0] ROUTE_PIN       = 2'h2;
  localparam logic [1:0] ROUTE_IRQ       = 2'h3;
  localparam logic [1:0] RESP_TYPICAL    = 2'h0;
  localparam logic [1:0] RESP_FAST       = 2'h3;

endpackage : cmp_ctrl_pkg

// File: hw/edge_sync.sv
// Purpose: Two-stage synchroniser with rise and fall detection
// Assumes: async_in is unrelated to clk
// Notes:   The first stage feeds only the second stage

`timescale 1ns/1ps

module edge_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic meta;
    logic stage;
    logic prev;
  } sync_s;

  sync_s sync_r;
  sync_s sync_nxt;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    sync_nxt       = sync_r;
    sync_nxt.meta  = async_in;
    sync_nxt.stage = sync_r.meta;
    sync_nxt.prev  = sync_r.stage;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= '0;
    end else if (clk_en) begin
      sync_r <= sync_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign level = sync_r.stage;
  assign rise  = sync_r.stage & ~sync_r.prev;
  assign fall  = ~sync_r.stage & sync_r.prev;

endmodule : edge_sync

// File: hw/cmp_ctrl.sv
// Purpose: Control and status logic for an on-chip voltage comparator
// Assumes: APB slave, zero wait states, pclk at 50 MHz
// Notes:   Analog comparator output arrives asynchronously
//
// Functional notes
// RULE_01 - Bit 10 powers and enables the comparator
// RULE_02 - Bits 9:8 select the negative input source
// RULE_03 - Bits 7:6 route result to pin or IRQ
// RULE_04 - Bit 5 inverts the comparator output sense
// RULE_05 - Bits 4:3 pick typical or fast response
// RULE_06 - Bit 2 turns on comparator hysteresis
// RULE_07 - Rising edge sets bit 1; write-one clears
// RULE_08 - Falling edge sets bit 0; write-one clears
// RULE_09 - Sixteen-bit control register, resets to zero
// RULE_10 - Result feeds IRQ, logic array, ADC, pin
// RULE_11 - Upper bits zero; flags need enable, sync
// RULE_12 - Zero write keeps flag; set beats clear

`timescale 1ns/1ps

module cmp_ctrl (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               pclk_en,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [cmp_ctrl_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [cmp_ctrl_pkg::DATA_W-1:0]    pwdata,
  input  wire logic [cmp_ctrl_pkg::STRB_W-1:0]    pstrb,
  output logic      [cmp_ctrl_pkg::DATA_W-1:0]    prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               cmp_raw_in,
  output logic                                    cmp_enable,
  output logic      [1:0]                         neg_input_select,
  output logic      [1:0]                         response_speed,
  output logic                                    hysteresis_on,
  output logic                                    output_polarity,
  output logic                                    compare_out_pin,
  output logic                                    cmp_irq,
  output logic                                    pla_cmp_out,
  output logic                                    adc_conv_trigger
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                             enable;
    logic [1:0]                       neg_sel;
    logic [1:0]                       routing;
    logic                             polarity;
    logic [1:0]                       resp;
    logic                             hyst;
    logic                             rise_event_flag;
    logic                             fall_event_flag;
    logic [cmp_ctrl_pkg::DATA_W-1:0]  rdata;
    logic                             pin;
    logic                             irq;
    logic                             pla;
    logic                             result_prev;
    logic                             trig;
  } ctrl_s;

  ctrl_s ctrl_r;
  ctrl_s ctrl_nxt;

  logic raw_level;
  logic raw_rise;
  logic raw_fall;

  logic hit_ctrl;
  logic hit_status;
  logic setup_phase;
  logic wr_access;
  logic result;

  logic [cmp_ctrl_pkg::CTRL_W-1:0] ctrl_view;
  logic [cmp_ctrl_pkg::DATA_W-1:0] status_view;

  // ---------------------------------------------------------------
  // Comparator output synchroniser
  // ---------------------------------------------------------------
  // RULE_11 sync before use
  edge_sync u_raw_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .clk_en   (pclk_en),
    .async_in (cmp_raw_in),
    .level    (raw_level),
    .rise     (raw_rise),
    .fall     (raw_fall)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign hit_ctrl    = (paddr == cmp_ctrl_pkg::CTRL_OFFSET);
  assign hit_status  = (paddr == cmp_ctrl_pkg::STATUS_OFFSET);
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite & hit_ctrl;

  // Answer waits while the clock enable holds state frozen
  assign pready  = pclk_en;
  assign pslverr = psel & penable & ~(hit_ctrl | hit_status);

  // ---------------------------------------------------------------
  // Register views
  // ---------------------------------------------------------------
  // RULE_11 upper bits zero
  always_comb begin
    ctrl_view = '0;
    ctrl_view[cmp_ctrl_pkg::EN_BIT] = ctrl_r.enable;
    ctrl_view[cmp_ctrl_pkg::NEG_LSB+1:cmp_ctrl_pkg::NEG_LSB] =
      ctrl_r.neg_sel;
    ctrl_view[cmp_ctrl_pkg::ROUTE_LSB+1:cmp_ctrl_pkg::ROUTE_LSB] =
      ctrl_r.routing;
    ctrl_view[cmp_ctrl_pkg::POL_BIT] = ctrl_r.polarity;
    ctrl_view[cmp_ctrl_pkg::RESP_LSB+1:cmp_ctrl_pkg::RESP_LSB] =
      ctrl_r.resp;
    ctrl_view[cmp_ctrl_pkg::HYST_BIT] = ctrl_r.hyst;
    ctrl_view[cmp_ctrl_pkg::RISE_BIT] = ctrl_r.rise_event_flag;
    ctrl_view[cmp_ctrl_pkg::FALL_BIT] = ctrl_r.fall_event_flag;
  end

  always_comb begin
    status_view = '0;
    status_view[cmp_ctrl_pkg::STAT_RAW_BIT] = raw_level;
    status_view[cmp_ctrl_pkg::STAT_RES_BIT] = result;
  end

  // ---------------------------------------------------------------
  // Comparator result
  // ---------------------------------------------------------------
  // RULE_04 polarity inversion
  assign result = ctrl_r.enable & (raw_level ^ ctrl_r.polarity);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;

    // Read data is captured in the setup cycle
    if (setup_phase) begin
      if (hit_ctrl) begin
        ctrl_nxt.rdata = {{(cmp_ctrl_pkg::DATA_W
                            - cmp_ctrl_pkg::CTRL_W){1'b0}}, ctrl_view};
      end else if (hit_status) begin
        ctrl_nxt.rdata = status_view;
      end else begin
        ctrl_nxt.rdata = '0;
      end
    end

    // Configuration fields, upper byte lane
    if (wr_access && pstrb[cmp_ctrl_pkg::HI_LANE]) begin
      // RULE_01 enable bit
      ctrl_nxt.enable  = pwdata[cmp_ctrl_pkg::EN_BIT];
      // RULE_02 negative input select
      ctrl_nxt.neg_sel =
        pwdata[cmp_ctrl_pkg::NEG_LSB+1:cmp_ctrl_pkg::NEG_LSB];
    end

    // Configuration fields, lower byte lane
    if (wr_access && pstrb[cmp_ctrl_pkg::LO_LANE]) begin
      // RULE_03 routing field
      ctrl_nxt.routing  =
        pwdata[cmp_ctrl_pkg::ROUTE_LSB+1:cmp_ctrl_pkg::ROUTE_LSB];
      // RULE_04 polarity bit
      ctrl_nxt.polarity = pwdata[cmp_ctrl_pkg::POL_BIT];
      // RULE_05 response field
      ctrl_nxt.resp     =
        pwdata[cmp_ctrl_pkg::RESP_LSB+1:cmp_ctrl_pkg::RESP_LSB];
      // RULE_06 hysteresis bit
      ctrl_nxt.hyst     = pwdata[cmp_ctrl_pkg::HYST_BIT];
      // RULE_07 write-one clear
      if (pwdata[cmp_ctrl_pkg::RISE_BIT]) begin
        ctrl_nxt.rise_event_flag = 1'b0;
      end
      // RULE_08 write-one clear
      if (pwdata[cmp_ctrl_pkg::FALL_BIT]) begin
        ctrl_nxt.fall_event_flag = 1'b0;
      end
    end

    // RULE_12 set beats clear
    // RULE_11 only while enabled
    if (ctrl_r.enable && raw_rise) begin
      // RULE_07 rising edge sets
      ctrl_nxt.rise_event_flag = 1'b1;
    end
    if (ctrl_r.enable && raw_fall) begin
      // RULE_08 falling edge sets
      ctrl_nxt.fall_event_flag = 1'b1;
    end

    // RULE_03 pin and IRQ routing
    ctrl_nxt.pin = result & (ctrl_r.routing == cmp_ctrl_pkg::ROUTE_PIN);
    ctrl_nxt.irq = result & (ctrl_r.routing == cmp_ctrl_pkg::ROUTE_IRQ);

    // RULE_10 logic array and ADC trigger
    ctrl_nxt.pla         = result;
    ctrl_nxt.result_prev = result;
    ctrl_nxt.trig        = result & ~ctrl_r.result_prev;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // RULE_09 reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
    end else if (pclk_en) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // RULE_01 analog power and enable
  assign cmp_enable       = ctrl_r.enable;
  // RULE_02 analog input mux
  assign neg_input_select = ctrl_r.neg_sel;
  // RULE_05 analog speed setting
  assign response_speed   = ctrl_r.resp;
  // RULE_06 analog hysteresis
  assign hysteresis_on    = ctrl_r.hyst;
  assign output_polarity  = ctrl_r.polarity;
  assign compare_out_pin  = ctrl_r.pin;
  assign cmp_irq          = ctrl_r.irq;
  assign pla_cmp_out      = ctrl_r.pla;
  assign adc_conv_trigger = ctrl_r.trig;
  assign prdata           = ctrl_r.rdata;

endmodule : cmp_ctrl

// File: tb/cmp_analog_model.sv
// Purpose: Behavioural analog comparator at the far side
// Assumes: above is 1 when positive input exceeds negative input
// Notes:   Output low while powered down
`timescale 1ns/1ps
module cmp_analog_model (
  input  wire logic cmp_enable,
  input  wire logic above,
  output logic      cmp_raw_in
);
  assign cmp_raw_in = cmp_enable & above;
endmodule : cmp_analog_model

// File: tb/cmp_ctrl_chk.sv
// Purpose: Port checks for cmp_ctrl
// Assumes: One pclk domain, presetn async low
// Notes:   Bound to every cmp_ctrl
`timescale 1ns/1ps
module cmp_ctrl_chk (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         pclk_en,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic [cmp_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         cmp_raw_in,
  input wire logic                         cmp_enable,
  input wire logic                         output_polarity,
  input wire logic                         compare_out_pin,
  input wire logic                         cmp_irq,
  input wire logic                         pla_cmp_out,
  input wire logic                         adc_conv_trigger
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ready;
    pready == pclk_en;
  endproperty
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  property p_ctrl_ok;
    psel && penable && paddr == cmp_ctrl_pkg::CTRL_OFFSET |-> !pslverr;
  endproperty
  property p_off;
    (!cmp_enable)[*3] |-> !pla_cmp_out;
  endproperty
  property p_one_route;
    !(compare_out_pin && cmp_irq);
  endproperty
  property p_pin_res;
    compare_out_pin |-> pla_cmp_out;
  endproperty
  property p_irq_res;
    cmp_irq |-> pla_cmp_out;
  endproperty
  property p_trig;
    adc_conv_trigger && pclk_en |=> !adc_conv_trigger;
  endproperty
  property p_sense;
    (cmp_enable && $stable(output_polarity) && $stable(cmp_raw_in))[*5]
      |-> pla_cmp_out == (cmp_raw_in ^ output_polarity);
  endproperty
  a_ready: assert property (p_ready) else $error("pready wrong");
  a_err_phase: assert property (p_err_phase) else $error("late err");
  a_ctrl_ok: assert property (p_ctrl_ok) else $error("ctrl err");
  a_off: assert property (p_off) else $error("result when off");
  a_one_route: assert property (p_one_route) else $error("two");
  a_pin_res: assert property (p_pin_res) else $error("pin");
  a_irq_res: assert property (p_irq_res) else $error("irq");
  a_trig: assert property (p_trig) else $error("trigger long");
  a_sense: assert property (p_sense) else $error("sense");
  c_trig: cover property (adc_conv_trigger);
  c_irq: cover property (cmp_irq);
  c_err: cover property (pslverr);
endmodule : cmp_ctrl_chk
bind cmp_ctrl cmp_ctrl_chk u_chk (
  .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .cmp_raw_in(cmp_raw_in), .cmp_enable(cmp_enable),
  .output_polarity(output_polarity), .compare_out_pin(compare_out_pin),
  .cmp_irq(cmp_irq), .pla_cmp_out(pla_cmp_out),
  .adc_conv_trigger(adc_conv_trigger)
);

// File: tb/cmp_ctrl_tb.sv
// Purpose: Register-level test of cmp_ctrl
// Assumes: Zero wait APB, pclk_en held high
// Notes:   Comparator model drives cmp_raw_in
`timescale 1ns/1ps
module cmp_ctrl_tb;
  logic        pclk, presetn, pclk_en, psel, penable, pwrite, above, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [1:0]  neg_input_select, response_speed;
  logic        pready, pslverr, cmp_raw_in, cmp_enable, hysteresis_on;
  logic        output_polarity, compare_out_pin, cmp_irq, pla_cmp_out;
  logic        adc_conv_trigger;
  int          num_errors, checks;
  cmp_ctrl u_dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw_in(cmp_raw_in), .cmp_enable(cmp_enable),
    .neg_input_select(neg_input_select), .response_speed(response_speed),
    .hysteresis_on(hysteresis_on), .output_polarity(output_polarity),
    .compare_out_pin(compare_out_pin), .cmp_irq(cmp_irq),
    .pla_cmp_out(pla_cmp_out), .adc_conv_trigger(adc_conv_trigger));
  cmp_analog_model u_model (.cmp_enable(cmp_enable), .above(above),
    .cmp_raw_in(cmp_raw_in));
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic idle(int n);
    repeat (n) @(negedge pclk);
  endtask : idle
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    pclk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; pstrb = 0; above = 0; presetn = 0;
    num_errors = 0; checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 32'h0, 4'h0); check("ctrl", rd, 32'h0);
    apb(1, 12'h000, 32'hFFFF, 4'hF);
    apb(0, 12'h000, 32'h0, 4'h0); check("ctrl", rd, 32'h7FC);
    idle(1);
    check("en", cmp_enable, 1);
    check("hyst", hysteresis_on, 1);
    apb(1, 12'h000, 32'h0, 4'h2);
    apb(0, 12'h000, 32'h0, 4'h0); check("lane", rd, 32'hFC);
    above <= 1;
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h000, 32'h400 | (i << 8) | (i << 6) | (i << 3), 4'h3);
      idle(4);
      check("neg", neg_input_select, i);
      check("resp", response_speed, i);
      check("pin", compare_out_pin, i == 2);
      check("irq", cmp_irq, i == 3);
    end
    apb(0, 12'h000, 32'h0, 4'h0); check("rise", rd, 32'h7DA);
    apb(1, 12'h000, 32'h4C2, 4'h3);
    apb(0, 12'h000, 32'h0, 4'h0); check("w1c", rd, 32'h4C0);
    @(posedge pclk);
    above <= 0;
    idle(6);
    apb(0, 12'h000, 32'h0, 4'h0); check("fall", rd, 32'h4C1);
    apb(1, 12'h000, 32'h4A1, 4'h3);
    idle(4);
    check("inv", compare_out_pin, 1);
    check("pol", output_polarity, 1);
    check("pla", pla_cmp_out, 1);
    apb(0, 12'h000, 32'h0, 4'h0); check("clr", rd, 32'h4A0);
    apb(0, 12'h004, 32'h0, 4'h0); check("stat", rd, 32'h2);
    apb(0, 12'h008, 32'h0, 4'h0); check("slverr", err, 1);
    // Rising edge lands on the same edge as the clearing write
    above <= 1;
    apb(1, 12'h000, 32'h4A3, 4'h1);
    apb(0, 12'h000, 32'h0, 4'h0); check("race", rd, 32'h4A2);
    // Falling edge caused by disabling must not set the flag
    apb(1, 12'h000, 32'h0, 4'h2);
    idle(6);
    check("off", pla_cmp_out, 0);
    apb(0, 12'h000, 32'h0, 4'h0); check("dis", rd, 32'hA2);
    tally_and_finish();
  end
endmodule : cmp_ctrl_tb
